// >>> logic/crd_core.sv
// core register datapath: alu, second operand, status word, stack, dual
// data pointers, scratch-pad and aux memories, idle and power-down gating.
// assumes the decoder issues one command per cycle while cpu_run_o is high.
`include "crd_cfg.svh"

module crd_core
  import crd_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  crd_pkg::crd_cmd_t     cmd_i,
  input  wire logic             idle_req_i,
  input  wire logic             pdown_req_i,
  input  wire logic             irq_i,
  output crd_pkg::crd_state_t   state_o,
  output logic      [7:0]       bank_base_o,
  output logic                  cpu_run_o,
  output logic                  periph_run_o,
  output logic                  pointer_select_bit_o
);
  crd_pm_t     pm_r, pm_nxt;
  logic [7:0]  acc_r, acc_nxt, b_r, b_nxt, psw_r, psw_nxt, sp_r, sp_nxt;
  logic [15:0] dp0_r, dp0_nxt, dp1_r, dp1_nxt, jmp_r, jmp_nxt;
  logic [7:0]  aux_control_one_r, aux_nxt, bank_r, bank_nxt;
  logic        cpu_r, cpu_nxt, per_r, per_nxt;
  logic        rd_aux_r, rd_aux_nxt, rd_bit_r, rd_bit_nxt;
  logic [2:0]  bsel_r, bsel_nxt;
  logic        ram_we, aux_we, ram_en, aux_en;
  logic [7:0]  ram_addr, ram_wdata, ram_rdata, aux_rdata;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic [15:0] prod;
  logic        cy_in, run;
  logic [15:0] dp_sel;

  assign run    = clk_en_i && cpu_r;
  assign dp_sel = aux_control_one_r[0] ? dp1_r : dp0_r;

  // power-management state keeps running while the cpu clock is stopped
  always_comb begin
    pm_nxt = pm_r;
    case (pm_r)
      CRD_PM_RUN: begin
        if (pdown_req_i) begin
          pm_nxt = CRD_PM_DOWN;
        end else if (idle_req_i) begin
          pm_nxt = CRD_PM_IDLE;
        end
      end
      CRD_PM_IDLE: begin
        if (pdown_req_i) begin
          pm_nxt = CRD_PM_DOWN;
        end else if (irq_i) begin
          pm_nxt = CRD_PM_RUN;
        end
      end
      CRD_PM_DOWN: pm_nxt = CRD_PM_DOWN;  // only reset leaves
      default: pm_nxt = CRD_PM_RUN;
    endcase
    cpu_nxt = (pm_nxt == CRD_PM_RUN);
    per_nxt = (pm_nxt != CRD_PM_DOWN);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pm_r  <= CRD_PM_RUN;
      cpu_r <= 1'b1;
      per_r <= 1'b1;
    end else if (clk_en_i) begin
      pm_r  <= pm_nxt;
      cpu_r <= cpu_nxt;
      per_r <= per_nxt;
    end
  end

  // datapath next state; holds everything while the cpu clock is stopped
  always_comb begin
    acc_nxt    = acc_r;
    b_nxt      = b_r;
    psw_nxt    = psw_r;
    sp_nxt     = sp_r;
    dp0_nxt    = dp0_r;
    dp1_nxt    = dp1_r;
    aux_nxt    = aux_control_one_r;
    jmp_nxt    = jmp_r;
    rd_aux_nxt = rd_aux_r;
    rd_bit_nxt = rd_bit_r;
    bsel_nxt   = bsel_r;
    ram_we     = 1'b0;
    aux_we     = 1'b0;
    ram_en     = 1'b0;
    aux_en     = 1'b0;
    ram_addr   = cmd_i.addr;
    ram_wdata  = cmd_i.wdata[7:0];
    cy_in      = (cmd_i.alu_op == CRD_OP_ADDC) && psw_r[`CRD_PSW_CY];
    sum9       = 9'h000;
    half5      = 5'h00;
    prod       = {8'h00, acc_r} * {8'h00, b_r};
    if (run) begin
      case (cmd_i.alu_op)
        CRD_OP_ADD, CRD_OP_ADDC: begin
          sum9  = {1'b0, acc_r} + {1'b0, cmd_i.wdata[7:0]} + {8'h00, cy_in};
          half5 = {1'b0, acc_r[3:0]} + {1'b0, cmd_i.wdata[3:0]} + {4'h0, cy_in};
          acc_nxt = sum9[7:0];
          psw_nxt[`CRD_PSW_CY] = sum9[8];
          psw_nxt[`CRD_PSW_AC] = half5[4];
          psw_nxt[`CRD_PSW_OV] = (acc_r[7] == cmd_i.wdata[7]) && (sum9[7] != acc_r[7]);
        end
        CRD_OP_SUBB: begin
          sum9  = {1'b0, acc_r} - {1'b0, cmd_i.wdata[7:0]} - {8'h00, psw_r[`CRD_PSW_CY]};
          half5 = {1'b0, acc_r[3:0]} - {1'b0, cmd_i.wdata[3:0]} - {4'h0, psw_r[`CRD_PSW_CY]};
          acc_nxt = sum9[7:0];
          psw_nxt[`CRD_PSW_CY] = sum9[8];
          psw_nxt[`CRD_PSW_AC] = half5[4];
          psw_nxt[`CRD_PSW_OV] = (acc_r[7] != cmd_i.wdata[7]) && (sum9[7] != acc_r[7]);
        end
        CRD_OP_AND: acc_nxt = acc_r & cmd_i.wdata[7:0];
        CRD_OP_OR:  acc_nxt = acc_r | cmd_i.wdata[7:0];
        CRD_OP_XOR: acc_nxt = acc_r ^ cmd_i.wdata[7:0];
        CRD_OP_MUL: begin
          acc_nxt = prod[7:0];
          b_nxt   = prod[15:8];
          psw_nxt[`CRD_PSW_CY] = 1'b0;
          psw_nxt[`CRD_PSW_OV] = (prod[15:8] != 8'h00);
        end
        CRD_OP_DIV: begin
          psw_nxt[`CRD_PSW_CY] = 1'b0;
          if (b_r == 8'h00) begin
            psw_nxt[`CRD_PSW_OV] = 1'b1;  // quotient undefined, operands kept
          end else begin
            acc_nxt = acc_r / b_r;
            b_nxt   = acc_r % b_r;
            psw_nxt[`CRD_PSW_OV] = 1'b0;
          end
        end
        CRD_OP_JADDR: jmp_nxt = cmd_i.jbase + {{8{acc_r[7]}}, acc_r};
        CRD_OP_LDA:   acc_nxt = cmd_i.wdata[7:0];
        CRD_OP_LDB:   b_nxt = cmd_i.wdata[7:0];
        default: ;
      endcase
      case (cmd_i.move)
        CRD_MV_PUSH: begin
          sp_nxt   = sp_r + 8'h01;
          ram_addr = sp_r + 8'h01;
          ram_en   = 1'b1;
          ram_we   = 1'b1;
        end
        CRD_MV_POP: begin
          sp_nxt     = sp_r - 8'h01;
          ram_addr   = sp_r;
          ram_en     = 1'b1;
          rd_aux_nxt = 1'b0;
          rd_bit_nxt = 1'b0;
        end
        CRD_MV_SPLD: sp_nxt = cmd_i.wdata[7:0];
        CRD_MV_RDRAM: begin
          ram_en     = 1'b1;
          rd_aux_nxt = 1'b0;
          rd_bit_nxt = 1'b0;
        end
        CRD_MV_WRRAM: begin
          ram_en = 1'b1;
          ram_we = 1'b1;
        end
        CRD_MV_RDBIT: begin
          ram_addr   = `CRD_BIT_BASE | {4'h0, cmd_i.addr[3:0]};
          ram_en     = 1'b1;
          rd_aux_nxt = 1'b0;
          rd_bit_nxt = 1'b1;
          bsel_nxt   = cmd_i.bit_sel;
        end
        CRD_MV_XRD: begin
          aux_en     = 1'b1;
          rd_aux_nxt = 1'b1;
          rd_bit_nxt = 1'b0;
        end
        CRD_MV_XWR: begin
          aux_en = 1'b1;
          aux_we = 1'b1;
        end
        CRD_MV_DPLD: begin
          if (aux_control_one_r[0]) begin
            dp1_nxt = cmd_i.wdata;
          end else begin
            dp0_nxt = cmd_i.wdata;
          end
        end
        CRD_MV_DPINC: begin
          if (aux_control_one_r[0]) begin
            dp1_nxt = dp1_r + 16'h0001;
          end else begin
            dp0_nxt = dp0_r + 16'h0001;
          end
        end
        CRD_MV_PSWLD: psw_nxt[7:1] = cmd_i.wdata[7:1];
        CRD_MV_AUXLD: aux_nxt = cmd_i.wdata[7:0];
        default: ;
      endcase
      psw_nxt[`CRD_PSW_P] = ^acc_nxt;
    end
    bank_nxt = {3'b000, psw_nxt[`CRD_PSW_RS_HI:`CRD_PSW_RS_LO], 3'b000};
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_r             <= `CRD_ACC_RST;
      b_r               <= `CRD_B_RST;
      psw_r             <= `CRD_PSW_RST;
      sp_r              <= `CRD_SP_RST;
      dp0_r             <= `CRD_DP_RST;
      dp1_r             <= `CRD_DP_RST;
      aux_control_one_r <= 8'h00;
      jmp_r             <= 16'h0000;
      rd_aux_r          <= 1'b0;
      rd_bit_r          <= 1'b0;
      bsel_r            <= 3'h0;
      bank_r            <= 8'h00;
    end else if (clk_en_i) begin
      acc_r             <= acc_nxt;
      b_r               <= b_nxt;
      psw_r             <= psw_nxt;
      sp_r              <= sp_nxt;
      dp0_r             <= dp0_nxt;
      dp1_r             <= dp1_nxt;
      aux_control_one_r <= aux_nxt;
      jmp_r             <= jmp_nxt;
      rd_aux_r          <= rd_aux_nxt;
      rd_bit_r          <= rd_bit_nxt;
      bsel_r            <= bsel_nxt;
      bank_r            <= bank_nxt;
    end
  end

  // memories are separate arrays, so external moves can never hit scratch-pad
  crd_ram #(.DEPTH(`CRD_RAM_DEPTH), .AW(8)) u_scratch (
    .ref_clk_i (ref_clk_i),
    .en_i      (ram_en && clk_en_i),
    .we_i      (ram_we),
    .addr_i    (ram_addr),
    .wdata_i   (ram_wdata),
    .rdata_o   (ram_rdata)
  );

  crd_ram #(.DEPTH(`CRD_AUX_DEPTH), .AW(8)) u_aux (
    .ref_clk_i (ref_clk_i),
    .en_i      (aux_en && clk_en_i),
    .we_i      (aux_we),
    .addr_i    (dp_sel[7:0]),
    .wdata_i   (acc_r),
    .rdata_o   (aux_rdata)
  );

  // read data is the memory register muxed; the struct is flopped below
  crd_state_t st_r;
  logic [7:0] rd_mux;
  always_comb begin
    if (rd_aux_r) begin
      rd_mux = aux_rdata;
    end else if (rd_bit_r) begin
      rd_mux = {7'h00, ram_rdata[bsel_r]};
    end else begin
      rd_mux = ram_rdata;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{`CRD_ACC_RST, `CRD_B_RST, `CRD_PSW_RST, `CRD_SP_RST, `CRD_DP_RST, 8'h00, 16'h0000};
    end else if (clk_en_i) begin
      st_r <= '{acc_nxt, b_nxt, psw_nxt, sp_nxt, aux_nxt[0] ? dp1_nxt : dp0_nxt, rd_mux, jmp_nxt};
    end
  end

  assign state_o              = st_r;
  assign bank_base_o          = bank_r;
  assign cpu_run_o            = cpu_r;
  assign periph_run_o         = per_r;
  assign pointer_select_bit_o = aux_control_one_r[0];
endmodule

// >>> logic/crd_cfg.svh
// constants of the core register datapath: reset values, field positions, sizes
// assumes inclusion by the datapath package and modules only
`ifndef CRD_CFG_SVH
`define CRD_CFG_SVH
`define CRD_SP_RST        8'h07
`define CRD_ACC_RST       8'h00
`define CRD_B_RST         8'h00
`define CRD_PSW_RST       8'h00
`define CRD_DP_RST        16'h0000
`define CRD_PSW_CY        7
`define CRD_PSW_AC        6
`define CRD_PSW_F0        5
`define CRD_PSW_RS_HI     4
`define CRD_PSW_RS_LO     3
`define CRD_PSW_OV        2
`define CRD_PSW_F1        1
`define CRD_PSW_P         0
`define CRD_BIT_BASE      8'h20
`define CRD_BIT_TOP       8'h2F
`define CRD_RAM_DEPTH     256
`define CRD_AUX_DEPTH     256
`endif

// >>> logic/crd_pkg.sv
// types shared by the core register datapath
// assumes crd_cfg.svh on the include path
package crd_pkg;
  typedef enum logic [3:0] {
    CRD_OP_NOP   = 4'h0,
    CRD_OP_ADD   = 4'h1,
    CRD_OP_ADDC  = 4'h2,
    CRD_OP_SUBB  = 4'h3,
    CRD_OP_AND   = 4'h4,
    CRD_OP_OR    = 4'h5,
    CRD_OP_XOR   = 4'h6,
    CRD_OP_MUL   = 4'h7,
    CRD_OP_DIV   = 4'h8,
    CRD_OP_JADDR = 4'h9,
    CRD_OP_LDA   = 4'hA,
    CRD_OP_LDB   = 4'hB
  } crd_alu_op_t;

  typedef enum logic [3:0] {
    CRD_MV_NONE  = 4'h0,
    CRD_MV_PUSH  = 4'h1,
    CRD_MV_POP   = 4'h2,
    CRD_MV_SPLD  = 4'h3,
    CRD_MV_RDRAM = 4'h4,
    CRD_MV_WRRAM = 4'h5,
    CRD_MV_RDBIT = 4'h6,
    CRD_MV_WRBIT = 4'h7,
    CRD_MV_XRD   = 4'h8,
    CRD_MV_XWR   = 4'h9,
    CRD_MV_DPLD  = 4'hA,
    CRD_MV_DPINC = 4'hB,
    CRD_MV_PSWLD = 4'hC,
    CRD_MV_AUXLD = 4'hD
  } crd_move_t;

  typedef enum logic [1:0] {
    CRD_PM_RUN  = 2'b00,
    CRD_PM_IDLE = 2'b01,
    CRD_PM_DOWN = 2'b10
  } crd_pm_t;

  typedef struct packed {
    crd_alu_op_t alu_op;
    crd_move_t   move;
    logic [7:0]  addr;
    logic [2:0]  bit_sel;
    logic [15:0] wdata;
    logic [15:0] jbase;
  } crd_cmd_t;

  typedef struct packed {
    logic [7:0]  accumulator_reg;
    logic [7:0]  second_operand;
    logic [7:0]  program_status_word;
    logic [7:0]  stack_top_pointer;
    logic [15:0] data_pointer_pair;
    logic [7:0]  rdata;
    logic [15:0] jump_addr;
  } crd_state_t;
endpackage

// >>> logic/crd_ram.sv
// single-port byte memory with registered read data
// assumes one access per enabled cycle; contents survive clock gating
module crd_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          ref_clk_i,
  input  wire logic          en_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [7:0]    wdata_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (en_i) begin
      if (we_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end
endmodule

// >>> test/crd_core_props.sv
// checker for the core register datapath, watching the core's ports only
// assumes crd_pkg is compiled first; bound to every crd_core below
module crd_core_props
  import crd_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  wire logic           sys_rst_i,
  input  wire logic           clk_en_i,
  input  crd_pkg::crd_cmd_t   cmd_i,
  input  wire logic           idle_req_i,
  input  wire logic           pdown_req_i,
  input  wire logic           irq_i,
  input  crd_pkg::crd_state_t state_o,
  input  wire logic           cpu_run_o,
  input  wire logic           periph_run_o,
  input  wire logic           pointer_select_bit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic go;
  assign go = clk_en_i && cpu_run_o;
  AST_PUSH: assert property (go && cmd_i.move == CRD_MV_PUSH |=>
    state_o.stack_top_pointer == $past(state_o.stack_top_pointer) + 8'h01) else $error("push pointer wrong");
  AST_POP: assert property (go && cmd_i.move == CRD_MV_POP |=>
    state_o.stack_top_pointer == $past(state_o.stack_top_pointer) - 8'h01) else $error("pop pointer wrong");
  AST_MUL: assert property (go && cmd_i.alu_op == CRD_OP_MUL |=>
    {state_o.second_operand, state_o.accumulator_reg} ==
    $past(state_o.accumulator_reg) * $past(state_o.second_operand)) else $error("product wrong");
  AST_PARITY: assert property (state_o.program_status_word[0] == ^state_o.accumulator_reg)
    else $error("parity flag wrong");
  AST_DPSEL: assert property (go && cmd_i.move == CRD_MV_AUXLD |=>
    pointer_select_bit_o == $past(cmd_i.wdata[0])) else $error("pointer select wrong");
  AST_IDLE: assert property (go && idle_req_i && !pdown_req_i && !irq_i |=>
    !cpu_run_o && periph_run_o) else $error("idle entry wrong");
  AST_FREEZE: assert property (!cpu_run_o |=> $stable(state_o.accumulator_reg))
    else $error("state moved while stopped");
  AST_PDOWN: assert property (clk_en_i && pdown_req_i |=> !cpu_run_o && !periph_run_o)
    else $error("power-down entry wrong");
  AST_PDHOLD: assert property (!periph_run_o |=> !periph_run_o && !cpu_run_o)
    else $error("left power-down without reset");
  AST_WAKE: assert property (clk_en_i && !cpu_run_o && periph_run_o && irq_i && !pdown_req_i |=>
    cpu_run_o) else $error("no wake on interrupt");
  cover property (go && cmd_i.move == CRD_MV_POP);
  cover property (!cpu_run_o && periph_run_o && irq_i);
  cover property (!periph_run_o);
endmodule

bind crd_core crd_core_props u_props (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .cmd_i(cmd_i), .idle_req_i(idle_req_i), .pdown_req_i(pdown_req_i), .irq_i(irq_i), .state_o(state_o),
  .cpu_run_o(cpu_run_o), .periph_run_o(periph_run_o), .pointer_select_bit_o(pointer_select_bit_o));

// >>> test/crd_core_test.sv
// self-checking bench for the core register datapath
// assumes crd_pkg and crd_core compiled before it; clock enable held high except for one dropped cycle
module crd_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import crd_pkg::*;
  logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1, idle_req_i = 1'b0, pdown_req_i = 1'b0, irq_i = 1'b0;
  logic        clk_en_i = 1'b1;
  crd_cmd_t    cmd_i = '0;
  crd_state_t  state_o;
  logic [7:0]  bank_base_o;
  logic        cpu_run_o, periph_run_o, pointer_select_bit_o;
  int          n_mismatch = 0, checked = 0, cyc = 0;

  crd_core DUT (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .cmd_i(cmd_i),
    .idle_req_i(idle_req_i), .pdown_req_i(pdown_req_i), .irq_i(irq_i), .state_o(state_o),
    .bank_base_o(bank_base_o), .cpu_run_o(cpu_run_o), .periph_run_o(periph_run_o),
    .pointer_select_bit_o(pointer_select_bit_o));

  always #10 ref_clk_i = ~ref_clk_i;

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // a hang costs at most this many cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      test_done;
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // request is taken at the following edge; the jump base repeats the data word
  task automatic op(input crd_alu_op_t a, input crd_move_t m, input logic [15:0] w);
    @(posedge ref_clk_i);
    cmd_i <= '{a, m, 8'h00, 3'h0, w, w};
  endtask

  // lets the last request land, then samples mid-cycle
  task automatic settle;
    @(posedge ref_clk_i);
    cmd_i <= '0;
    @(negedge ref_clk_i);
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    settle;
    chk(state_o.stack_top_pointer, 16'h07);
    chk({cpu_run_o, periph_run_o, pointer_select_bit_o, bank_base_o}, 16'h600);
    op(CRD_OP_LDA, CRD_MV_NONE, 16'hA5);
    clk_en_i <= 1'b0;
    op(CRD_OP_NOP, CRD_MV_NONE, 16'h00);
    clk_en_i <= 1'b1;
    settle;
    chk(state_o.accumulator_reg, 16'h00);
    op(CRD_OP_LDA, CRD_MV_NONE, 16'h5A);
    op(CRD_OP_LDB, CRD_MV_NONE, 16'h03);
    op(CRD_OP_MUL, CRD_MV_NONE, 16'h00);
    settle;
    chk({state_o.second_operand, state_o.accumulator_reg}, 16'h010E);
    chk(state_o.program_status_word[0], 16'h1);
    op(CRD_OP_NOP, CRD_MV_PUSH, 16'h33);
    op(CRD_OP_NOP, CRD_MV_PUSH, 16'h44);
    op(CRD_OP_NOP, CRD_MV_POP, 16'h00);
    settle;
    chk(state_o.stack_top_pointer, 16'h08);
    settle;
    chk(state_o.rdata, 16'h44);
    op(CRD_OP_NOP, CRD_MV_POP, 16'h00);
    settle;
    settle;
    chk({state_o.stack_top_pointer, state_o.rdata}, 16'h0733);
    op(CRD_OP_NOP, CRD_MV_SPLD, 16'h1F);
    op(CRD_OP_NOP, CRD_MV_PUSH, 16'hA5);
    op(CRD_OP_NOP, CRD_MV_RDBIT, 16'h00);
    settle;
    settle;
    chk({state_o.stack_top_pointer, state_o.rdata}, 16'h2001);
    op(CRD_OP_NOP, CRD_MV_PSWLD, 16'h18);
    settle;
    settle;
    chk(bank_base_o, 16'h18);
    op(CRD_OP_NOP, CRD_MV_AUXLD, 16'h01);
    op(CRD_OP_NOP, CRD_MV_DPLD, 16'h1234);
    op(CRD_OP_NOP, CRD_MV_AUXLD, 16'h00);
    settle;
    chk(state_o.data_pointer_pair, 16'h0000);
    op(CRD_OP_NOP, CRD_MV_AUXLD, 16'h01);
    op(CRD_OP_NOP, CRD_MV_XWR, 16'h00);
    op(CRD_OP_LDA, CRD_MV_NONE, 16'h00);
    op(CRD_OP_NOP, CRD_MV_XRD, 16'h00);
    settle;
    chk(state_o.data_pointer_pair, 16'h1234);
    settle;
    chk(state_o.rdata, 16'h0E);
    op(CRD_OP_LDA, CRD_MV_NONE, 16'h7F);
    op(CRD_OP_ADD, CRD_MV_NONE, 16'h01);
    settle;
    chk({state_o.accumulator_reg, state_o.program_status_word}, 16'h805D);
    op(CRD_OP_SUBB, CRD_MV_NONE, 16'h81);
    op(CRD_OP_JADDR, CRD_MV_NONE, 16'h1000);
    settle;
    chk({state_o.accumulator_reg, state_o.program_status_word}, 16'hFFD8);
    chk(state_o.jump_addr, 16'h0FFF);
    op(CRD_OP_AND, CRD_MV_NONE, 16'h0F);
    op(CRD_OP_OR, CRD_MV_NONE, 16'h30);
    op(CRD_OP_XOR, CRD_MV_NONE, 16'h0A);
    op(CRD_OP_LDB, CRD_MV_NONE, 16'h06);
    op(CRD_OP_DIV, CRD_MV_NONE, 16'h00);
    settle;
    chk({state_o.second_operand, state_o.accumulator_reg}, 16'h0508);
    chk(state_o.program_status_word, 16'h59);
    op(CRD_OP_LDB, CRD_MV_NONE, 16'h00);
    op(CRD_OP_DIV, CRD_MV_NONE, 16'h00);
    settle;
    chk({state_o.accumulator_reg, state_o.program_status_word}, 16'h085D);
    @(posedge ref_clk_i);
    idle_req_i <= 1'b1;
    op(CRD_OP_LDA, CRD_MV_NONE, 16'h77);
    idle_req_i <= 1'b0;
    settle;
    chk({cpu_run_o, periph_run_o, state_o.accumulator_reg}, 16'h108);
    @(posedge ref_clk_i);
    irq_i <= 1'b1;
    settle;
    chk({cpu_run_o, state_o.accumulator_reg}, 16'h108);
    op(CRD_OP_NOP, CRD_MV_NONE, 16'h00);
    irq_i       <= 1'b0;
    pdown_req_i <= 1'b1;
    @(posedge ref_clk_i);
    pdown_req_i <= 1'b0;
    irq_i       <= 1'b1;
    settle;
    settle;
    chk({cpu_run_o, periph_run_o}, 16'h0);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    irq_i     <= 1'b0;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    settle;
    chk({cpu_run_o, periph_run_o, state_o.stack_top_pointer}, 16'h307);
    test_done;
  end
endmodule
